//--- logic/dram_pll_irq_defs.svh
`ifndef DRAM_PLL_IRQ_DEFS_SVH
`define DRAM_PLL_IRQ_DEFS_SVH

// register indexes; byte address is four times the index
`define IDX_MEMCFG 8'h66
`define IDX_FEN1 8'hB0
`define IDX_FEN2 8'hB1
`define IDX_STEER 8'hB2
`define IDX_FEN3 8'hB4
`define IDX_STATUS 8'hC0

// field positions, dram_pll_crystal_config
`define RAMSEL_LO_BIT 7
`define RAMSEL_HI_BIT 6
`define PLL_HI_BIT 4
`define PLL_LO_BIT 3
`define XTAL_EN_BIT 2
`define FEN2_MASK 8'hFC

// field positions, companion registers
`define SRC_SEL_BIT 6
`define EXT_EN_BIT 7
`define FEN3_MASK 8'hC0
`define LEG_HI_BIT 4
`define LEG_LO_BIT 2
`define PAGE_BIT 0
`define MEMCFG_MASK 8'h1D

// field positions, irq_steering_config
`define ROUTE_B_HI 7
`define ROUTE_B_LO 4
`define ROUTE_A_HI 3
`define ROUTE_A_LO 0

// reset values
`define RST_MEMCFG 8'h00
`define RST_FEN1 8'h00
`define RST_FEN2 8'h00
`define RST_STEER 8'h00
`define RST_FEN3 8'h00

// fixed levels when the full ISA bus is in use
`define ISA_IRQ_A 4'h3
`define ISA_IRQ_B 4'h6

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- logic/dram_pll_irq_pkg.sv
`default_nettype none
package dram_pll_irq_pkg;
  typedef enum logic [1:0] {
    DRAM_512K_ONE,
    DRAM_1M_TWO,
    DRAM_2M_ONE,
    DRAM_4M_TWO
  } dram_mode_t;

  typedef enum logic [1:0] {
    PLL_40MHZ,
    PLL_50MHZ,
    PLL_66MHZ,
    PLL_RESERVED
  } pll_freq_t;

  typedef logic [1:0] axi_resp_t;
endpackage : dram_pll_irq_pkg
`default_nettype wire

//--- logic/steer_if.sv
`timescale 1ns/10ps
`default_nettype none
interface steer_if;
  logic [3:0] codeA;
  logic [3:0] codeB;
  logic irqA;
  logic irqB;
  logic localBus;
  logic [15:0] irqLines;
  modport ctrl (
    output codeA, codeB, irqA, irqB, localBus,
    input irqLines
  );
  modport router (
    input codeA, codeB, irqA, irqB, localBus,
    output irqLines
  );
endinterface : steer_if
`default_nettype wire

//--- logic/irq_router.sv
`timescale 1ns/10ps
`default_nettype none
`include "dram_pll_irq_defs.svh"
module irq_router (
  input wire logic clock,
  input wire logic rstLocal_n,
  steer_if.router steer
);
  import dram_pll_irq_pkg::*;

  // one-hot level for a steering code; reserved codes give none
  function automatic logic [15:0] routeLevel(input logic [3:0] code);
    logic [15:0] hot;
    hot = 16'h0000;
    case (code)
      4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
      4'h9, 4'hA, 4'hB, 4'hC,
      4'hE, 4'hF: hot[code] = 1'b1;
      default: hot = 16'h0000;
    endcase
    return hot;
  endfunction : routeLevel

  logic [3:0] levelA;
  logic [3:0] levelB;
  logic [15:0] irqLines_ff;

  // steering only in local bus mode, fixed levels otherwise
  assign levelA = steer.localBus ? steer.codeA : `ISA_IRQ_A;
  assign levelB = steer.localBus ? steer.codeB : `ISA_IRQ_B;

  // registered merge of both routed inputs
  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      irqLines_ff <= 16'h0000;
    end else begin
      irqLines_ff <= ({16{steer.irqA}} & routeLevel(levelA)) |
                     ({16{steer.irqB}} & routeLevel(levelB));
    end
  end
  assign steer.irqLines = irqLines_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstLocal_n);

  chk_isa_fixed: assert property (
    (!steer.localBus && steer.irqA && steer.irqB) |=>
      (irqLines_ff == 16'h0048))
    else $error("isa mode inputs not on levels 3 and 6");
  chk_reserved_none: assert property (
    (steer.localBus && steer.codeA == 4'hD && !steer.irqB) |=>
      (irqLines_ff == 16'h0000))
    else $error("reserved code drove a level");
  chk_route_level: assert property (
    (steer.localBus && steer.irqB && !steer.irqA &&
     steer.codeB == 4'hE) |=> (irqLines_ff == 16'h4000))
    else $error("code 1110 not on level 14");
endmodule : irq_router
`default_nettype wire

//--- logic/dram_pll_irq_steering_config.sv
// What this block does
// - ram mode field in bits 7 and 6
// - extended enable takes dram mode from field
// - codes 00/01 give 512K or 1M
// - codes 10/11 give 2M or 4M
// - legacy ram mode ignored when extended
// - page mode bit still honoured when extended
// - pll frequency field in bits 4 and 3
// - crystal bit drives 14.336 MHz out while source select is clear
// - two four-bit interrupt steering fields
// - steering code to irq level map
// - steering only in local bus mode
// - source select drives baud clock out
// - extended dram enable in companion bit 7
`timescale 1ns/10ps
`default_nettype none
`include "dram_pll_irq_defs.svh"
module dram_pll_irq_steering_config (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [11:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output dram_pll_irq_pkg::axi_resp_t bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output dram_pll_irq_pkg::axi_resp_t rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic localBusMode,
  input wire logic steerableIrqInA,
  input wire logic steerableIrqInB,
  input wire logic crystalClockIn,
  input wire logic uartBaudClock,
  output logic [15:0] irqLines,
  output logic dramExtended,
  output dram_pll_irq_pkg::dram_mode_t dramMode,
  output logic bank1Present,
  output logic [2:0] legacyRamMode,
  output logic enhancedPageMode,
  output dram_pll_irq_pkg::pll_freq_t pllFreqSel,
  output logic pllFreqReserved,
  output logic crystalClockOut,
  output logic crystalClockOutEn
);
  import dram_pll_irq_pkg::*;

  // word index of a byte address, or 8'h00 when outside the map
  function automatic logic [7:0] wordIndex(input logic [11:0] addr);
    return (addr[11:10] == 2'b00) ? addr[9:2] : 8'h00;
  endfunction : wordIndex

  // whether an index names one of our registers
  function automatic logic isMapped(input logic [7:0] idx);
    return (idx == `IDX_MEMCFG) || (idx == `IDX_FEN1) ||
           (idx == `IDX_FEN2) || (idx == `IDX_STEER) ||
           (idx == `IDX_FEN3) || (idx == `IDX_STATUS);
  endfunction : isMapped

  logic [1:0] rstSync_ff;
  logic rstLocal_n;
  logic [4:0] pinMeta_ff;
  logic [4:0] pinSync_ff;
  logic localSync;
  logic irqASync;
  logic irqBSync;
  logic xtalSync;
  logic baudSync;

  logic [7:0] memCfg_ff;
  logic [7:0] fen1_ff;
  logic [7:0] fen2_ff;
  logic [7:0] steerCfg_ff;
  logic [7:0] fen3_ff;

  logic wrTake;
  logic arTake;
  logic [7:0] wrIdx;
  logic [7:0] rdIdx;
  logic wrByte;
  logic bvalid_ff;
  axi_resp_t bresp_ff;
  logic rvalid_ff;
  axi_resp_t rresp_ff;
  logic [31:0] rdata_ff;
  logic [7:0] statusWord;

  logic dramExtended_ff;
  dram_mode_t dramMode_ff;
  logic bank1Present_ff;
  logic [2:0] legacyRamMode_ff;
  logic enhancedPageMode_ff;
  pll_freq_t pllFreqSel_ff;
  logic pllFreqReserved_ff;
  logic crystalClockOut_ff;
  logic crystalClockOutEn_ff;
  logic extEn;
  dram_mode_t nxt_dramMode;

  steer_if steer ();

  // reset release through two flip-flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_ff <= 2'b00;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'b1};
    end
  end
  assign rstLocal_n = rstSync_ff[1];

  // two-stage synchronisers for all pin inputs
  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      pinMeta_ff <= 5'h00;
      pinSync_ff <= 5'h00;
    end else begin
      pinMeta_ff <= {uartBaudClock, crystalClockIn, steerableIrqInB,
                     steerableIrqInA, localBusMode};
      pinSync_ff <= pinMeta_ff;
    end
  end
  assign localSync = pinSync_ff[0];
  assign irqASync = pinSync_ff[1];
  assign irqBSync = pinSync_ff[2];
  assign xtalSync = pinSync_ff[3];
  assign baudSync = pinSync_ff[4];

  // write channel: address and data taken together, one at a time
  assign wrTake = awvalid && wvalid && !bvalid_ff;
  assign awready = wrTake;
  assign wready = wrTake;
  assign wrIdx = wordIndex(awaddr);
  assign wrByte = wrTake && wstrb[0];

  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
    end else if (wrTake) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= isMapped(wrIdx) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // dram, pll and crystal configuration
  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      fen2_ff <= `RST_FEN2;
    end else if (wrByte && wrIdx == `IDX_FEN2) begin
      fen2_ff <= wdata[7:0] & `FEN2_MASK;
    end
  end

  // interrupt steering fields
  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      steerCfg_ff <= `RST_STEER;
    end else if (wrByte && wrIdx == `IDX_STEER) begin
      steerCfg_ff <= wdata[7:0];
    end
  end

  // companion registers: memory config, source select, extended enable
  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      memCfg_ff <= `RST_MEMCFG;
      fen1_ff <= `RST_FEN1;
      fen3_ff <= `RST_FEN3;
    end else if (wrByte) begin
      if (wrIdx == `IDX_MEMCFG) begin
        memCfg_ff <= wdata[7:0] & `MEMCFG_MASK;
      end
      if (wrIdx == `IDX_FEN1) begin
        fen1_ff <= {1'b0, wdata[`SRC_SEL_BIT], 6'h00};
      end
      if (wrIdx == `IDX_FEN3) begin
        fen3_ff <= wdata[7:0] & `FEN3_MASK;
      end
    end
  end

  // read channel, one outstanding read
  assign arTake = arvalid && !rvalid_ff;
  assign arready = arTake;
  assign rdIdx = wordIndex(araddr);
  assign statusWord = {localSync, dramExtended_ff, dramMode_ff,
                       pllFreqSel_ff, crystalClockOutEn_ff,
                       pllFreqReserved_ff};

  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= `RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (arTake) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= isMapped(rdIdx) ? `RESP_OKAY : `RESP_SLVERR;
      case (rdIdx)
        `IDX_MEMCFG: rdata_ff <= {24'h000000, memCfg_ff};
        `IDX_FEN2: rdata_ff <= {24'h000000, fen2_ff};
        `IDX_STEER: rdata_ff <= {24'h000000, steerCfg_ff};
        `IDX_FEN3: rdata_ff <= {24'h000000, fen3_ff};
        `IDX_STATUS: rdata_ff <= {24'h000000, statusWord};
        default: rdata_ff <= 32'h0000_0000; // source select is write-only
      endcase
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;

  // dram mode decode: bit 7 is mode bit 0, bit 6 is mode bit 1
  assign extEn = fen3_ff[`EXT_EN_BIT];
  always_comb begin
    case ({fen2_ff[`RAMSEL_HI_BIT], fen2_ff[`RAMSEL_LO_BIT]})
      2'b00: nxt_dramMode = DRAM_512K_ONE;
      2'b01: nxt_dramMode = DRAM_1M_TWO;
      2'b10: nxt_dramMode = DRAM_2M_ONE;
      2'b11: nxt_dramMode = DRAM_4M_TWO;
      default: nxt_dramMode = DRAM_512K_ONE;
    endcase
  end

  // registered memory configuration outputs
  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      dramExtended_ff <= 1'b0;
      dramMode_ff <= DRAM_512K_ONE;
      bank1Present_ff <= 1'b0;
      legacyRamMode_ff <= 3'h0;
      enhancedPageMode_ff <= 1'b0;
    end else begin
      dramExtended_ff <= extEn;
      dramMode_ff <= nxt_dramMode;
      bank1Present_ff <= extEn && nxt_dramMode[0];
      legacyRamMode_ff <= extEn ? 3'h0 :
                          memCfg_ff[`LEG_HI_BIT:`LEG_LO_BIT];
      enhancedPageMode_ff <= memCfg_ff[`PAGE_BIT];
    end
  end

  // pll frequency select; reserved code is flagged, not altered
  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      pllFreqSel_ff <= PLL_40MHZ;
      pllFreqReserved_ff <= 1'b0;
    end else begin
      pllFreqSel_ff <= pll_freq_t'(fen2_ff[`PLL_HI_BIT:`PLL_LO_BIT]);
      pllFreqReserved_ff <= &fen2_ff[`PLL_HI_BIT:`PLL_LO_BIT];
    end
  end

  // crystal output pin: baud clock, crystal clock or three-state
  always_ff @(posedge clock or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      crystalClockOut_ff <= 1'b0;
      crystalClockOutEn_ff <= 1'b0;
    end else begin
      crystalClockOut_ff <= fen1_ff[`SRC_SEL_BIT] ? baudSync :
                            xtalSync;
      crystalClockOutEn_ff <= fen1_ff[`SRC_SEL_BIT] ||
                              fen2_ff[`XTAL_EN_BIT];
    end
  end

  assign dramExtended = dramExtended_ff;
  assign dramMode = dramMode_ff;
  assign bank1Present = bank1Present_ff;
  assign legacyRamMode = legacyRamMode_ff;
  assign enhancedPageMode = enhancedPageMode_ff;
  assign pllFreqSel = pllFreqSel_ff;
  assign pllFreqReserved = pllFreqReserved_ff;
  assign crystalClockOut = crystalClockOut_ff;
  assign crystalClockOutEn = crystalClockOutEn_ff;

  // interrupt steering
  assign steer.codeA = steerCfg_ff[`ROUTE_A_HI:`ROUTE_A_LO];
  assign steer.codeB = steerCfg_ff[`ROUTE_B_HI:`ROUTE_B_LO];
  assign steer.irqA = irqASync;
  assign steer.irqB = irqBSync;
  assign steer.localBus = localSync;

  irq_router router (
    .clock(clock),
    .rstLocal_n(rstLocal_n),
    .steer(steer)
  );
  assign irqLines = steer.irqLines;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstLocal_n);

  sequence fen2Write(logic [7:0] val);
    wrByte && wrIdx == `IDX_FEN2 && wdata[7:0] == val;
  endsequence

  sequence fen3Enable;
    wrByte && wrIdx == `IDX_FEN3 && wdata[7];
  endsequence

  chk_ram_field_order: assert property (
    fen2Write(8'h88) ##1 (extEn && !wrByte) |=>
      (dramMode == DRAM_1M_TWO))
    else $error("bit 7 did not act as mode bit 0");
  chk_ext_enable: assert property (
    fen3Enable ##1 1'b1 |=> dramExtended)
    else $error("extended dram mode not taken");
  chk_ext_off: assert property (
    !extEn |=> !dramExtended && !bank1Present)
    else $error("extended mode shown while disabled");
  chk_bank_layout: assert property (
    dramExtended |-> (bank1Present == (dramMode == DRAM_1M_TWO ||
                                       dramMode == DRAM_4M_TWO)))
    else $error("second bank presence wrong");
  chk_big_mode: assert property (
    (extEn && fen2_ff[7:6] == 2'b01) |=> (dramMode == DRAM_2M_ONE))
    else $error("code 10 not decoded as 2 Mbyte");
  chk_legacy_masked: assert property (
    dramExtended |-> (legacyRamMode == 3'h0))
    else $error("legacy ram mode leaks in extended mode");
  chk_page_kept: assert property (
    ##1 (enhancedPageMode == $past(memCfg_ff[`PAGE_BIT])))
    else $error("page mode bit not followed");
  chk_pll_select: assert property (
    fen2Write(8'h50) |=> ##1 (pllFreqSel == PLL_66MHZ))
    else $error("pll field not decoded");
  chk_crystal_tristate: assert property (
    (!fen1_ff[`SRC_SEL_BIT] && !fen2_ff[`XTAL_EN_BIT]) |=>
      !crystalClockOutEn)
    else $error("crystal pin driven while off");
  chk_crystal_drive: assert property (
    (!fen1_ff[`SRC_SEL_BIT] && fen2_ff[`XTAL_EN_BIT]) |=>
      (crystalClockOutEn && crystalClockOut == $past(xtalSync)))
    else $error("crystal clock not on pin");
  chk_baud_source: assert property (
    fen1_ff[`SRC_SEL_BIT] |=>
      (crystalClockOutEn && crystalClockOut == $past(baudSync)))
    else $error("baud clock not on pin");
  chk_write_answer: assert property (
    wrTake |=> bvalid [*1] ##0 (!awready && !wready))
    else $error("write not answered next cycle");
endmodule : dram_pll_irq_steering_config
`default_nettype wire

//--- sim/dram_pll_irq_steering_config_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "dram_pll_irq_defs.svh"
module dram_pll_irq_steering_config_tb;
  import dram_pll_irq_pkg::*;
  typedef struct {logic [3:0] code; logic [15:0] irq;} row_t;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic localBusMode = 1'b1;
  logic irqInA = 1'b0;
  logic irqInB = 1'b0;
  logic crystalClockIn = 1'b1;
  logic uartBaudClock = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  axi_resp_t bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] irqLines;
  logic dramExtended, bank1Present, enhancedPageMode, pllFreqReserved;
  dram_mode_t dramMode;
  pll_freq_t pllFreqSel;
  logic [2:0] legacyRamMode;
  logic crystalClockOut, crystalClockOutEn;
  int nFail = 0;
  int nChecks = 0;
  // steering code beside the interrupt line it should raise
  row_t rows [16] = '{
    '{4'h0, 16'h0000}, '{4'h1, 16'h0000}, '{4'h2, 16'h0000},
    '{4'h3, 16'h0008}, '{4'h4, 16'h0010}, '{4'h5, 16'h0020},
    '{4'h6, 16'h0040}, '{4'h7, 16'h0080}, '{4'h8, 16'h0000},
    '{4'h9, 16'h0200}, '{4'hA, 16'h0400}, '{4'hB, 16'h0800},
    '{4'hC, 16'h1000}, '{4'hD, 16'h0000}, '{4'hE, 16'h4000},
    '{4'hF, 16'h8000}};

  dram_pll_irq_steering_config DUT (
    .clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .localBusMode(localBusMode),
    .steerableIrqInA(irqInA), .steerableIrqInB(irqInB),
    .crystalClockIn(crystalClockIn), .uartBaudClock(uartBaudClock),
    .irqLines(irqLines), .dramExtended(dramExtended), .dramMode(dramMode),
    .bank1Present(bank1Present), .legacyRamMode(legacyRamMode),
    .enhancedPageMode(enhancedPageMode), .pllFreqSel(pllFreqSel),
    .pllFreqReserved(pllFreqReserved), .crystalClockOut(crystalClockOut),
    .crystalClockOutEn(crystalClockOutEn));

  // free running 100 MHz clock
  always #5 clock = ~clock;

  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      nFail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wt

  // address and data offered together, each dropped once taken
  task automatic axiWrite(input logic [11:0] a, input logic [7:0] d,
                          output axi_resp_t r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clock);
      if (!ad && awready === 1'b1) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (!wd && wready === 1'b1) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [11:0] a, output logic [31:0] d,
                         output axi_resp_t r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axiRead

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    axi_resp_t r;
    axiWrite({2'b00, idx, 2'b00}, d, r);
    chk("bresp", `RESP_OKAY, r);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    axi_resp_t r;
    logic [31:0] d;
    axiRead({2'b00, idx, 2'b00}, d, r);
    chk("rresp", `RESP_OKAY, r);
    chk("rdata", {24'h0, e}, d);
  endtask : rd

  task automatic pins(input logic a, input logic b, input logic lb);
    @(posedge clock);
    irqInA <= a;
    irqInB <= b;
    localBusMode <= lb;
  endtask : pins

  // main sequence
  initial begin
    logic [1:0] m;
    logic [31:0] d;
    axi_resp_t r;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    wt(3);
    chk("irqLines", 32'h0, irqLines);
    rd(`IDX_FEN2, `RST_FEN2);
    rd(`IDX_STEER, `RST_STEER);
    for (int i = 0; i < 16; i++) begin
      pins(1'b1, 1'b0, 1'b1);
      wr(`IDX_STEER, {4'h0, rows[i].code});
      wt(5);
      chk("irqLines A", rows[i].irq, irqLines);
      pins(1'b0, 1'b1, 1'b1);
      wr(`IDX_STEER, {rows[i].code, 4'h0});
      wt(5);
      chk("irqLines B", rows[i].irq, irqLines);
    end
    rd(`IDX_STEER, 8'hF0);
    pins(1'b1, 1'b1, 1'b0);
    wt(5);
    chk("irqLines isa", 16'h0048, irqLines);
    pins(1'b0, 1'b0, 1'b1);
    wr(`IDX_MEMCFG, 8'h1D);
    wt(3);
    chk("legacyRamMode", 3'h7, legacyRamMode);
    chk("dramExtended", 1'b0, dramExtended);
    wr(`IDX_FEN3, 8'h80);
    wt(3);
    rd(`IDX_FEN3, 8'h80);
    chk("dramExtended", 1'b1, dramExtended);
    chk("legacyRamMode", 3'h0, legacyRamMode);
    chk("enhancedPageMode", 1'b1, enhancedPageMode);
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      wr(`IDX_FEN2, {m[0], m[1], 1'b0, m, 3'h0});
      wt(3);
      chk("dramMode", m, dramMode);
      chk("bank1Present", m[0], bank1Present);
      chk("pllFreqSel", m, pllFreqSel);
      chk("pllFreqReserved", m == 2'h3, pllFreqReserved);
      rd(`IDX_FEN2, {m[0], m[1], 1'b0, m, 3'h0});
    end
    wr(`IDX_FEN2, 8'h04);
    wt(5);
    chk("crystalClockOutEn", 1'b1, crystalClockOutEn);
    chk("crystalClockOut", 1'b1, crystalClockOut);
    wr(`IDX_FEN1, 8'h40);
    wt(5);
    chk("crystalClockOut", 1'b0, crystalClockOut);
    rd(`IDX_FEN1, 8'h00);
    wr(`IDX_FEN2, 8'h00);
    wt(5);
    chk("crystalClockOutEn", 1'b1, crystalClockOutEn);
    wr(`IDX_FEN1, 8'h00);
    wt(5);
    chk("crystalClockOutEn", 1'b0, crystalClockOutEn);
    rd(`IDX_STATUS, 8'hC0);
    wr(`IDX_FEN2, 8'hFF);
    rd(`IDX_FEN2, 8'hFC);
    axiWrite(12'hC00, 8'hFF, r);
    chk("bresp unmapped", `RESP_SLVERR, r);
    axiRead(12'hC00, d, r);
    chk("rresp unmapped", `RESP_SLVERR, r);
    chk("rdata unmapped", 32'h0, d);
    // second reset in mid-run clears the registers again
    @(posedge clock);
    rst_n <= 1'b0;
    wt(4);
    @(posedge clock);
    rst_n <= 1'b1;
    wt(3);
    rd(`IDX_FEN2, `RST_FEN2);
    rd(`IDX_STEER, `RST_STEER);
    conclude();
  end

  // watchdog against a hung handshake
  initial begin
    #200000;
    nFail++;
    conclude();
  end
endmodule : dram_pll_irq_steering_config_tb
`default_nettype wire
